// File: pcgd_cfg.svh
// offsets, field positions, masks and reset values of the clock gate block
`ifndef PCGD_CFG_SVH
`define PCGD_CFG_SVH

`define PCGD_ADDR_W 16
`define PCGD_NREG 6
// disable registers sit at page 0xf2xx, one 16-byte slot per register
`define PCGD_DIS_PAGE 8'hf2
`define PCGD_DIS_FIRST 4'h4
`define PCGD_DIS_LAST 4'h9
// alias operation codes in address bits 3:2 (+0x0, +0x4, +0x8, +0xc)
`define PCGD_OP_WRITE 2'h0
`define PCGD_OP_CLR 2'h1
`define PCGD_OP_SET 2'h2
`define PCGD_OP_INV 2'h3
// configuration control and unlock key registers
`define PCGD_CONFIG_CTRL_ADDR 16'hf200
`define PCGD_KEY_ADDR 16'hf230
`define PCGD_KEY_FIRST 32'h1357_9bdf
`define PCGD_KEY_SECOND 32'h2468_ace0
`define PCGD_LOCK_BIT 12
`define PCGD_LOCK_RST 1'h0
`define PCGD_ONE_WAY_BIT 28
// implemented bits of each disable register
`define PCGD_MASK_ANALOG 32'h0010_1101
`define PCGD_MASK_COMP 32'h0000_0007
`define PCGD_MASK_CAPCMP 32'h001f_001f
`define PCGD_MASK_TIMERS 32'h0000_001f
`define PCGD_MASK_SERIAL 32'h0103_0303
`define PCGD_MASK_MISC 32'h0001_0003
`define PCGD_DIS_RST 32'h0000_0000
// bit positions of named disable bits
`define PCGD_ADC_BIT 0
`define PCGD_USB_BIT 24

`endif

// File: pcgd_pkg.sv
// types shared by the peripheral clock gate block
package pcgd_pkg;

  typedef logic [31:0] pcgd_word_t;

  // one word per disable register, analog group first
  typedef struct packed {
    pcgd_word_t analog;
    pcgd_word_t comparators;
    pcgd_word_t capture_compare;
    pcgd_word_t timers;
    pcgd_word_t serial;
    pcgd_word_t misc;
  } pcgd_dis_s;

  // unlock sequence states
  typedef enum logic [2:0] {
    PCGD_KEY_IDLE = 3'b001,
    PCGD_KEY_HALF = 3'b010,
    PCGD_KEY_OPEN = 3'b100
  } pcgd_key_e;

endpackage : pcgd_pkg

// File: pcgd_top.sv
// peripheral clock gate disable registers, lock and unlock sequence
//
// Summary of operation
// - set disable bit stops that peripheral's clocks
// - disabled peripheral ignores register writes, reads invalid
// - one disables, zero enables, reset all enabled (clock enables held at zero during reset, set on the first edge after it)
// - analog, comparator, capture/compare bit positions fixed
// - timer, serial, misc bit positions; others absent
// - locked writes complete silently, contents unchanged
// - lock bit twelve blocks disable register writes
// - lock bit changes only after unlock sequence
// - one-way setting holds lock until reset
// - clear, set, invert aliases at 4, 8, c
`timescale 1ns/10ps
`include "pcgd_cfg.svh"

module pcgd_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] config_word_three_i,
  output logic [31:0] rdata_o,
  output pcgd_pkg::pcgd_dis_s periph_clk_en_o,
  output pcgd_pkg::pcgd_dis_s periph_reg_block_o,
  output logic disable_reg_lock_o
);
  import pcgd_pkg::*;

  // implemented bits of register idx
  function automatic pcgd_word_t mask_of(input logic [2:0] idx);
    case (idx)
      3'h0: mask_of = `PCGD_MASK_ANALOG;
      3'h1: mask_of = `PCGD_MASK_COMP;
      3'h2: mask_of = `PCGD_MASK_CAPCMP;
      3'h3: mask_of = `PCGD_MASK_TIMERS;
      3'h4: mask_of = `PCGD_MASK_SERIAL;
      3'h5: mask_of = `PCGD_MASK_MISC;
      default: mask_of = 32'h0000_0000;
    endcase
  endfunction : mask_of

  // new value of a disable register for a plain or alias write
  function automatic pcgd_word_t upd(input pcgd_word_t old,
                                     input pcgd_word_t wd,
                                     input logic [1:0] op,
                                     input pcgd_word_t msk);
    pcgd_word_t v;
    v = old;
    case (op)
      `PCGD_OP_WRITE: v = wd;
      `PCGD_OP_CLR: v = old & ~wd;
      `PCGD_OP_SET: v = old | wd;
      `PCGD_OP_INV: v = old ^ wd;
      default: v = old;
    endcase
    upd = v & msk;
  endfunction : upd

  // array of six words into the output struct, analog first
  function automatic pcgd_dis_s pack(input pcgd_word_t a [`PCGD_NREG]);
    pack = {a[0], a[1], a[2], a[3], a[4], a[5]};
  endfunction : pack

  pcgd_word_t dis_q [`PCGD_NREG];
  pcgd_word_t dis_d [`PCGD_NREG];
  pcgd_dis_s en_q;
  pcgd_dis_s en_d;
  pcgd_dis_s dis_flat;
  pcgd_dis_s mask_flat;
  pcgd_key_e key_q;
  pcgd_key_e key_d;
  logic lock_q;
  logic lock_d;
  logic one_way_q;
  logic strap_done_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // address decode
  wire [3:0] slot = addr_i[7:4];
  wire hit_dis = (addr_i[15:8] == `PCGD_DIS_PAGE) &&
                 (slot >= `PCGD_DIS_FIRST) && (slot <= `PCGD_DIS_LAST);
  wire [2:0] idx = 3'(slot - `PCGD_DIS_FIRST);
  wire [1:0] op = addr_i[3:2];
  wire hit_cfg = (addr_i == `PCGD_CONFIG_CTRL_ADDR);
  wire hit_key = (addr_i == `PCGD_KEY_ADDR);
  wire key_open = (key_q == PCGD_KEY_OPEN);

  // locked writes are accepted on the bus but dropped here
  wire dis_wr = wr_i && hit_dis && !lock_q;
  wire cfg_wr = wr_i && hit_cfg && key_open;
  wire new_lock = wdata_i[`PCGD_LOCK_BIT];

  // next disable register values, aliases included
  always_comb begin
    for (int i = 0; i < `PCGD_NREG; i++) begin
      dis_d[i] = dis_q[i];
    end
    if (dis_wr) begin
      dis_d[idx] = upd(dis_q[idx], wdata_i, op, mask_of(idx));
    end
  end

  // enables are the inverse of implemented disable bits
  assign dis_flat = pack(dis_q);
  assign mask_flat = {`PCGD_MASK_ANALOG, `PCGD_MASK_COMP,
                      `PCGD_MASK_CAPCMP, `PCGD_MASK_TIMERS,
                      `PCGD_MASK_SERIAL, `PCGD_MASK_MISC};
  assign en_d = ~pack(dis_d) & mask_flat;

  // unlock sequence: two keys on consecutive bus writes
  always_comb begin
    key_d = key_q;
    case (key_q)
      PCGD_KEY_IDLE: begin
        if (wr_i && hit_key && wdata_i == `PCGD_KEY_FIRST) begin
          key_d = PCGD_KEY_HALF;
        end
      end
      PCGD_KEY_HALF: begin
        if (wr_i || rd_i) begin
          key_d = (wr_i && hit_key && wdata_i == `PCGD_KEY_SECOND) ?
                  PCGD_KEY_OPEN : PCGD_KEY_IDLE;
        end
      end
      PCGD_KEY_OPEN: begin
        // any key write closes the window again
        if (wr_i && hit_key) begin
          key_d = (wdata_i == `PCGD_KEY_FIRST) ?
                  PCGD_KEY_HALF : PCGD_KEY_IDLE;
        end
      end
      default: key_d = PCGD_KEY_IDLE;
    endcase
  end

  // lock bit; one-way strap forbids clearing once set
  always_comb begin
    lock_d = lock_q;
    if (cfg_wr) begin
      lock_d = (one_way_q && lock_q) ? 1'b1 : new_lock;
    end
  end

  // read mux; aliases and unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_i) begin
      if (hit_dis && op == `PCGD_OP_WRITE) begin
        rdata_d = dis_q[idx];
      end else if (hit_cfg) begin
        rdata_d[`PCGD_LOCK_BIT] = lock_q;
      end else if (hit_key) begin
        rdata_d[0] = key_open;
      end
    end
  end

  // disable registers and clock enables
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `PCGD_NREG; i++) begin
        dis_q[i] <= `PCGD_DIS_RST;
      end
      en_q <= '0;
    end else begin
      dis_q <= dis_d;
      en_q <= en_d;
    end
  end

  // lock, unlock state and read data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_q <= `PCGD_LOCK_RST;
      key_q <= PCGD_KEY_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      lock_q <= lock_d;
      key_q <= key_d;
      rdata_q <= rdata_d;
    end
  end

  // one-way strap caught once, on the first edge after reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      one_way_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      one_way_q <= config_word_three_i[`PCGD_ONE_WAY_BIT];
      strap_done_q <= 1'b1;
    end
  end

  // enables come from flops, so a downstream latch gate never
  // sees a mid-cycle change and cannot clip a clock pulse
  assign periph_clk_en_o = en_q;
  // peripheral register ports must drop writes while disabled
  assign periph_reg_block_o = dis_flat;
  assign disable_reg_lock_o = lock_q;
  assign rdata_o = rdata_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // locked write leaves every disable bit alone
  a_locked_write_kept: assert property (
    (wr_i && hit_dis && lock_q) |=> dis_flat == $past(dis_flat))
    else $error("locked write changed a disable register");

  // set alias ors written ones into the analog register
  a_set_alias_or: assert property (
    (dis_wr && op == `PCGD_OP_SET && idx == 3'h0) |=>
      dis_q[0] == ($past(dis_q[0]) | ($past(wdata_i) &
                   `PCGD_MASK_ANALOG)))
    else $error("set alias did not or in the bits");

  // clock enable is exactly the complement of the disable bit
  // enables sit at zero in reset, so skip the edge right after it
  a_enable_tracks_bit: assert property (
    !$past(rst_i) |->
      ((dis_flat & en_q) == '0) && ((dis_flat | en_q) == mask_flat))
    else $error("clock enable disagrees with disable bit");

  // usb disable reaches the register block one edge later
  a_usb_block_late: assert property (
    (dis_wr && idx == 3'h4 && op == `PCGD_OP_SET &&
     wdata_i[`PCGD_USB_BIT]) |=>
      periph_reg_block_o.serial[`PCGD_USB_BIT] &&
      !periph_clk_en_o.serial[`PCGD_USB_BIT])
    else $error("usb disable not applied next cycle");

  // absent peripherals never show a disable bit
  a_absent_bits_zero: assert property (
    (dis_flat & ~mask_flat) == '0)
    else $error("unimplemented disable bit set");

  // without the key sequence the lock cannot move
  a_lock_needs_key: assert property (
    (wr_i && hit_cfg && !key_open) |=> lock_q == $past(lock_q))
    else $error("lock changed without unlock sequence");

  // one-way strap keeps the lock set for good
  a_one_way_hold: assert property (
    (one_way_q && lock_q) |=> lock_q [*2])
    else $error("one-way lock was cleared");

  // lock write after unlock takes effect next edge
  a_lock_write_takes: assert property (
    (cfg_wr && new_lock) |=> lock_q ##1 (lock_q || key_open))
    else $error("lock bit write lost");

  // clear on the adc bit enables its clock next edge
  a_adc_clear_enables: assert property (
    (dis_wr && idx == 3'h0 && op == `PCGD_OP_CLR &&
     wdata_i[`PCGD_ADC_BIT]) |=>
      periph_clk_en_o.analog[`PCGD_ADC_BIT])
    else $error("adc clear did not restore clock");

  // plain read answers the cycle after, with the stored value
  a_read_next_cycle: assert property (
    (rd_i && hit_dis && op == `PCGD_OP_WRITE && idx == 3'h3) |=>
      rdata_o == $past(dis_q[3]))
    else $error("timer register read data wrong");

  // read data fall back to zero when no read was made
  a_rdata_idle_zero: assert property (
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero without a read");

  // unlocked plain write stores the implemented bits
  a_unlocked_write_lands: assert property (
    (wr_i && hit_dis && !lock_q && op == `PCGD_OP_WRITE &&
     idx == 3'h0) |=>
      dis_q[0] == ($past(wdata_i) & `PCGD_MASK_ANALOG))
    else $error("unlocked write did not land");

  // clear alias removes every written one
  a_clr_alias_and: assert property (
    (dis_wr && op == `PCGD_OP_CLR && idx == 3'h0) |=>
      (dis_q[0] & $past(wdata_i)) == 32'h0000_0000)
    else $error("clear alias left a bit set");

  // invert alias toggles the written ones of the serial register
  a_inv_alias_xor: assert property (
    (dis_wr && op == `PCGD_OP_INV && idx == 3'h4) |=>
      dis_q[4] == ($past(dis_q[4]) ^ ($past(wdata_i) &
                   `PCGD_MASK_SERIAL)))
    else $error("invert alias did not toggle the bits");

  // strap is frozen once caught, later pin changes are ignored
  a_strap_once: assert property (
    strap_done_q |=> $stable(one_way_q))
    else $error("one-way strap changed after capture");

endmodule : pcgd_top

// File: pcgd_top_tb.sv
// self-checking bench for the peripheral clock gate block
`timescale 1ns/10ps
`include "pcgd_cfg.svh"

module pcgd_top_tb;
  import pcgd_pkg::*;
  typedef struct {
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } pcgd_row_s;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] config_word_three_i = 32'h0000_0000;
  logic [31:0] rdata_o;
  pcgd_dis_s periph_clk_en_o;
  pcgd_dis_s periph_reg_block_o;
  logic disable_reg_lock_o;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] msk [6];
  pcgd_row_s rows [12];

  pcgd_top dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .config_word_three_i(config_word_three_i),
    .rdata_o(rdata_o),
    .periph_clk_en_o(periph_clk_en_o),
    .periph_reg_block_o(periph_reg_block_o),
    .disable_reg_lock_o(disable_reg_lock_o)
  );

  always #25 mclk_i = ~mclk_i;

  // hang guard, the run needs about 140 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one-cycle write strobe, outputs settled on return
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // read data only stand in the cycle after the strobe
  task automatic rdchk(input string nm, input logic [15:0] a,
                       input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rdchk

  task automatic unlock();
    wr(16'hf230, `PCGD_KEY_FIRST);
    wr(16'hf230, `PCGD_KEY_SECOND);
  endtask : unlock

  task automatic do_reset(input logic strap);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    config_word_three_i <= {3'h0, strap, 28'h0};
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
  endtask : do_reset

  function automatic logic [31:0] fld(input pcgd_dis_s s, input int i);
    logic [191:0] v;
    v = s;
    return v[191-32*i -: 32];
  endfunction : fld

  initial begin
    msk = '{`PCGD_MASK_ANALOG, `PCGD_MASK_COMP, `PCGD_MASK_CAPCMP,
            `PCGD_MASK_TIMERS, `PCGD_MASK_SERIAL, `PCGD_MASK_MISC};
    // base writes of all ones, analog clear and set aliases, serial clear, set and invert aliases, then a serial zero write
    rows = '{'{16'hf240, 32'hffff_ffff, `PCGD_MASK_ANALOG},
             '{16'hf244, 32'h0000_0001, 32'h0010_1100},
             '{16'hf248, 32'h0000_0001, `PCGD_MASK_ANALOG},
             '{16'hf250, 32'hffff_ffff, `PCGD_MASK_COMP},
             '{16'hf260, 32'hffff_ffff, `PCGD_MASK_CAPCMP},
             '{16'hf270, 32'hffff_ffff, `PCGD_MASK_TIMERS},
             '{16'hf280, 32'hffff_ffff, `PCGD_MASK_SERIAL},
             '{16'hf290, 32'hffff_ffff, `PCGD_MASK_MISC},
             '{16'hf284, 32'h0000_0303, 32'h0103_0000},
             '{16'hf288, 32'h0100_0001, 32'h0103_0001},
             '{16'hf28c, 32'h0100_0003, 32'h0003_0002},
             '{16'hf280, 32'h0000_0000, 32'h0000_0000}};
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      rdchk("reset value", {8'hf2, 4'(i + 4), 4'h0}, 32'h0);
      chk("reset clock enable", msk[i], fld(periph_clk_en_o, i));
    end
    chk("reset lock", 32'h0, {31'h0, disable_reg_lock_o});
    foreach (rows[i]) begin
      int r;
      r = int'(rows[i].a[7:4]) - 4;
      // nothing runs behind the enables, so no module-off step first
      wr(rows[i].a, rows[i].d);
      chk("block", rows[i].e, fld(periph_reg_block_o, r));
      chk("clk en", msk[r] & ~rows[i].e, fld(periph_clk_en_o, r));
      rdchk("readback", {rows[i].a[15:4], 4'h0}, rows[i].e);
    end
    rdchk("alias read", 16'hf288, 32'h0);
    rdchk("unmapped read", 16'hf2f0, 32'h0);
    @(posedge mclk_i);
    #1;
    chk("rdata idle", 32'h0, rdata_o);
    // lock set after unlock, then disable writes silently dropped
    unlock();
    wr(16'hf200, 32'h0000_1000);
    chk("lock set", 32'h1, {31'h0, disable_reg_lock_o});
    rdchk("config read", 16'hf200, 32'h0000_1000);
    wr(16'hf240, 32'h0000_0000);
    wr(16'hf288, 32'h0000_0001);
    rdchk("locked write", 16'hf240, `PCGD_MASK_ANALOG);
    rdchk("locked set", 16'hf280, 32'h0);
    // a new key write closes the window, lock change refused
    wr(16'hf230, 32'h0000_0000);
    wr(16'hf200, 32'h0000_0000);
    chk("lock kept", 32'h1, {31'h0, disable_reg_lock_o});
    unlock();
    wr(16'hf200, 32'h0000_0000);
    chk("lock cleared", 32'h0, {31'h0, disable_reg_lock_o});
    wr(16'hf240, 32'h0000_0000);
    rdchk("unlocked write", 16'hf240, 32'h0);
    // an access between the keys aborts the sequence
    wr(16'hf230, `PCGD_KEY_FIRST);
    rdchk("key state", 16'hf230, 32'h0);
    wr(16'hf230, `PCGD_KEY_SECOND);
    wr(16'hf200, 32'h0000_1000);
    chk("aborted unlock", 32'h0, {31'h0, disable_reg_lock_o});
    // one-way strap: lock cannot clear until reset
    do_reset(1'b1);
    chk("reset lock", 32'h0, {31'h0, disable_reg_lock_o});
    rdchk("reset value", 16'hf240, 32'h0);
    unlock();
    wr(16'hf200, 32'h0000_1000);
    unlock();
    wr(16'hf200, 32'h0000_0000);
    chk("one-way lock", 32'h1, {31'h0, disable_reg_lock_o});
    do_reset(1'b0);
    chk("lock after reset", 32'h0, {31'h0, disable_reg_lock_o});
    report_and_stop();
  end
endmodule : pcgd_top_tb
